// ### rlm_pkg.sv
// Package: constants, opcodes and states of the register-load and accumulate datapath
// Behaviour
// - Load-overflow-counter copies operand bits 15:10 into the 6-bit counter only.
// - Non-repeatable loads after a repeat prefix clear the repeat count, run once.
// - Load-product-high writes operand to product upper half, lower half and flags kept.
// - Load-product-low writes operand to product lower half, upper half and flags kept.
// - Load-shift-mode copies bits 2:0 of chosen sum half into shift field.
// - Load-multiplicand writes operand to multiplicand upper half, flags untouched.
// - Clear-multiplicand-low zeroes multiplicand lower half, keeps upper half, no flags.
// - Save-program-counter loads selected aux pointer with zero-extended 22-bit counter.
// - Accumulate variant loads multiplicand high and adds shifted product to sum register.
// - Repeated accumulate runs N+1 times; overflow flag sticky, other flags final.
// - After accumulate, negative is sum bit 31, zero set when sum is zero.
// - Carry flag follows carry out of the accumulate addition.
// - Overflow flag set on accumulate overflow, otherwise left unchanged.
// - Saturation off: counter increments on positive, decrements on negative overflow.
// - Saturation on: overflowing sum clamps to most positive or most negative value.
// - Left product shift zero-fills; right product shift replicates the sign bit.
package rlm_pkg;

    // Opcode words and masks (first instruction word)
    localparam logic [15:0] OP_LOAD_OVF_CNT   = 16'h5602;
    localparam logic [15:0] OP_CLR_MCAND_LOW  = 16'h5656;
    localparam logic [15:0] OP_LOAD_SHIFT     = 16'h5638;
    localparam logic [15:0] MASK_LOAD_SHIFT   = 16'hFFFE;
    localparam logic [15:0] OP_SAVE_PC        = 16'h3E58;
    localparam logic [15:0] MASK_SAVE_PC      = 16'hFFF8;
    localparam logic [7:0]  OP_LOAD_PROD_HIGH = 8'h2F;
    localparam logic [7:0]  OP_LOAD_PROD_LOW  = 8'h27;
    localparam logic [7:0]  OP_LOAD_MCAND     = 8'h2D;
    localparam logic [7:0]  OP_LOAD_MCAND_ADD = 8'h10;

    // Field positions
    localparam int OVF_CNT_MSB  = 15;
    localparam int OVF_CNT_LSB  = 10;
    localparam int SHIFT_W      = 3;
    localparam int PC_W         = 22;
    localparam int AUX_SEL_W    = 3;
    localparam int OVF_CNT_W    = 6;

    // Reset values
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [15:0] RST_HALF     = 16'h0000;
    localparam logic [5:0]  RST_OVF_CNT  = 6'h00;
    localparam logic [2:0]  RST_SHIFT    = 3'h0;
    localparam logic [15:0] RST_REPEAT   = 16'h0000;
    localparam logic [15:0] ZERO_HALF    = 16'h0000;

    // Saturation limits
    localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
    localparam logic [31:0] SAT_NEG = 32'h8000_0000;

    // Execution states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REPEAT
    } rlm_state_type;

endpackage

// ### rlm_accum.sv
// Shifted-product accumulate step with flags, overflow counter and saturation
`timescale 1ns/100ps
module rlm_accum
    import rlm_pkg::*;
(
    input  wire logic [31:0] sum_in,      // Current sum register
    input  wire logic [31:0] product,     // Product register
    input  wire logic [2:0]  shift_field, // Product shift field
    input  wire logic        sat_en,      // Saturation enable
    input  wire logic [5:0]  cnt_in,      // Current overflow counter
    output logic      [31:0] sum_out,     // New sum
    output logic             carry_out,   // Carry of addition
    output logic             ovf_out,     // Overflow occurred
    output logic             neg_out,     // Negative flag
    output logic             zero_out,    // Zero flag
    output logic      [5:0]  cnt_out      // New overflow counter
);

    logic [31:0] shifted;
    logic [32:0] raw;
    logic        pos_ovf;
    logic        neg_ovf;

    // Shift decode: 0 = left 1, 1 = none, 2..7 = right 1..6
    always_comb begin
        case (shift_field)
            3'h0:    shifted = {product[30:0], 1'b0};
            3'h1:    shifted = product;
            default: shifted = 32'($signed(product) >>> (shift_field - 3'h1));
        endcase
    end

    // Addition, overflow detection and saturation
    always_comb begin
        raw       = {1'b0, sum_in} + {1'b0, shifted};
        carry_out = raw[32];
        pos_ovf   = !sum_in[31] && !shifted[31] && raw[31];
        neg_ovf   = sum_in[31] && shifted[31] && !raw[31];
        ovf_out   = pos_ovf || neg_ovf;
        sum_out   = raw[31:0];
        cnt_out   = cnt_in;
        if (sat_en && pos_ovf) begin
            sum_out = SAT_POS;
        end else if (sat_en && neg_ovf) begin
            sum_out = SAT_NEG;
        end else if (pos_ovf) begin
            cnt_out = cnt_in + 6'h01;
        end else if (neg_ovf) begin
            cnt_out = cnt_in - 6'h01;
        end
        neg_out  = sum_out[31];
        zero_out = (sum_out == RST_WORD);
    end

endmodule

// ### rlm_exec.sv
// Execution datapath for register-load and load-and-accumulate instructions
`timescale 1ns/100ps
module rlm_exec
    import rlm_pkg::*;
(
    input  wire logic        MCLK,           // Core clock
    input  wire logic        RESET,          // Asynchronous reset, active high
    input  wire logic        CLK_EN,         // Clock enable, freezes state when low
    input  wire logic        INSTR_VALID,    // Instruction issue strobe
    input  wire logic [15:0] INSTR_WORD,     // First opcode word
    input  wire logic [15:0] MEM_OPERAND_16, // Operand from addressing unit
    input  wire logic        REPEAT_PREFIX,  // Repeat prefix strobe
    input  wire logic [15:0] REPEAT_N,       // Repeat prefix count N
    input  wire logic [21:0] PC_IN,          // Program counter
    input  wire logic [31:0] SUM_IN,         // Sum register from core
    input  wire logic        SATURATE_ENABLE, // Saturation mode
    output logic             READY,          // Accepts next instruction
    output logic             SUM_WE,         // Sum register write pulse
    output logic      [31:0] SUM_OUT,        // New sum value
    output logic      [5:0]  OVERFLOW_COUNTER, // Overflow counter
    output logic      [15:0] MULT_RESULT_HIGH, // Product upper half
    output logic      [15:0] MULT_RESULT_LOW,  // Product lower half
    output logic      [2:0]  RESULT_SHIFT_FIELD, // Product shift field
    output logic      [31:0] MULTIPLICAND_REG, // Multiplicand register
    output logic      [15:0] REPEAT_COUNT_REG, // Remaining repeats
    output logic             AUX_WE,         // Aux pointer write pulse
    output logic      [2:0]  AUX_SEL,        // Aux pointer index
    output logic      [31:0] AUX_POINTER,    // Aux pointer data
    output logic             FLAG_N,         // Negative flag
    output logic             FLAG_Z,         // Zero flag
    output logic             FLAG_C,         // Carry flag
    output logic             FLAG_V          // Overflow flag
);

    rlm_state_type state_ff, nxt_state;
    logic [5:0]  cnt_ff, nxt_cnt;
    logic [15:0] prod_hi_ff, nxt_prod_hi, prod_lo_ff, nxt_prod_lo;
    logic [2:0]  shf_ff, nxt_shf;
    logic [31:0] mcand_ff, nxt_mcand;
    logic [15:0] rcnt_ff, nxt_rcnt;
    logic        aux_we_ff, nxt_aux_we;
    logic [2:0]  aux_sel_ff, nxt_aux_sel;
    logic [31:0] aux_ff, nxt_aux;
    logic        sum_we_ff, nxt_sum_we;
    logic [31:0] sum_ff, nxt_sum;
    logic        n_ff, nxt_n, z_ff, nxt_z, c_ff, nxt_c, v_ff, nxt_v;
    logic        armed_ff, nxt_armed;

    logic        is_ldcnt, is_lhigh, is_llow, is_lshift, is_t, is_mclr, is_pc, is_mac;
    logic [31:0] mac_src;
    logic [31:0] mac_sum;
    logic [5:0]  mac_cnt;
    logic        mac_c, mac_v, mac_n, mac_z;

    // Opcode decode
    always_comb begin
        is_ldcnt  = (INSTR_WORD == OP_LOAD_OVF_CNT);
        is_mclr   = (INSTR_WORD == OP_CLR_MCAND_LOW);
        is_lshift = ((INSTR_WORD & MASK_LOAD_SHIFT) == OP_LOAD_SHIFT);
        is_pc     = ((INSTR_WORD & MASK_SAVE_PC) == OP_SAVE_PC);
        is_lhigh  = (INSTR_WORD[15:8] == OP_LOAD_PROD_HIGH);
        is_llow   = (INSTR_WORD[15:8] == OP_LOAD_PROD_LOW);
        is_t      = (INSTR_WORD[15:8] == OP_LOAD_MCAND);
        is_mac    = (INSTR_WORD[15:8] == OP_LOAD_MCAND_ADD);
    end

    // Repeated passes chain on the held sum, first pass uses core sum
    assign mac_src = (state_ff == ST_REPEAT) ? sum_ff : SUM_IN;

    rlm_accum u_accum (
        .sum_in      (mac_src),
        .product     ({prod_hi_ff, prod_lo_ff}),
        .shift_field (shf_ff),
        .sat_en      (SATURATE_ENABLE),
        .cnt_in      (cnt_ff),
        .sum_out     (mac_sum),
        .carry_out   (mac_c),
        .ovf_out     (mac_v),
        .neg_out     (mac_n),
        .zero_out    (mac_z),
        .cnt_out     (mac_cnt)
    );

    // Busy while an accumulate repeat is running
    assign READY = (state_ff == ST_IDLE);

    // Next-state and datapath update
    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_prod_hi   = prod_hi_ff;
        nxt_prod_lo   = prod_lo_ff;
        nxt_shf       = shf_ff;
        nxt_mcand     = mcand_ff;
        nxt_rcnt      = rcnt_ff;
        nxt_armed     = armed_ff;
        nxt_aux_we    = 1'b0;
        nxt_aux_sel   = aux_sel_ff;
        nxt_aux       = aux_ff;
        nxt_sum_we    = 1'b0;
        nxt_sum       = sum_ff;
        nxt_n         = n_ff;
        nxt_z         = z_ff;
        nxt_c         = c_ff;
        nxt_v         = v_ff;
        case (state_ff)
            ST_IDLE: begin
                if (REPEAT_PREFIX) begin
                    nxt_rcnt  = REPEAT_N;
                    nxt_armed = 1'b1;
                end else if (INSTR_VALID) begin
                    nxt_armed = 1'b0;
                    if (is_mac) begin
                        nxt_mcand[31:16] = MEM_OPERAND_16;
                        nxt_sum          = mac_sum;
                        nxt_sum_we       = 1'b1;
                        nxt_cnt          = mac_cnt;
                        nxt_n            = mac_n;
                        nxt_z            = mac_z;
                        nxt_c            = mac_c;
                        nxt_v            = v_ff | mac_v;
                        if (armed_ff && rcnt_ff != RST_REPEAT) begin
                            nxt_state = ST_REPEAT;
                        end else begin
                            nxt_rcnt = RST_REPEAT;
                        end
                    end else begin
                        nxt_rcnt = RST_REPEAT;
                        if (is_ldcnt) begin
                            nxt_cnt = MEM_OPERAND_16[OVF_CNT_MSB:OVF_CNT_LSB];
                        end else if (is_lhigh) begin
                            nxt_prod_hi = MEM_OPERAND_16;
                        end else if (is_llow) begin
                            nxt_prod_lo = MEM_OPERAND_16;
                        end else if (is_lshift) begin
                            nxt_shf = INSTR_WORD[0] ? SUM_IN[SHIFT_W+15:16] : SUM_IN[SHIFT_W-1:0];
                        end else if (is_t) begin
                            nxt_mcand[31:16] = MEM_OPERAND_16;
                        end else if (is_mclr) begin
                            nxt_mcand[15:0] = ZERO_HALF;
                        end else if (is_pc) begin
                            nxt_aux_we  = 1'b1;
                            nxt_aux_sel = INSTR_WORD[AUX_SEL_W-1:0];
                            nxt_aux     = {10'h000, PC_IN};
                        end
                    end
                end
            end
            ST_REPEAT: begin
                // Further passes: flags track last, overflow flag sticky
                nxt_sum    = mac_sum;
                nxt_sum_we = 1'b1;
                nxt_cnt    = mac_cnt;
                nxt_n      = mac_n;
                nxt_z      = mac_z;
                nxt_c      = mac_c;
                nxt_v      = v_ff | mac_v;
                nxt_rcnt   = rcnt_ff - 16'h0001;
                if (rcnt_ff == 16'h0001) begin
                    nxt_state = ST_IDLE;
                    nxt_armed = 1'b0;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= RST_OVF_CNT;
            prod_hi_ff   <= RST_HALF;
            prod_lo_ff   <= RST_HALF;
            shf_ff       <= RST_SHIFT;
            mcand_ff     <= RST_WORD;
            rcnt_ff      <= RST_REPEAT;
            armed_ff     <= 1'b0;
            aux_we_ff    <= 1'b0;
            aux_sel_ff   <= 3'h0;
            aux_ff       <= RST_WORD;
            sum_we_ff    <= 1'b0;
            sum_ff       <= RST_WORD;
            n_ff         <= 1'b0;
            z_ff         <= 1'b0;
            c_ff         <= 1'b0;
            v_ff         <= 1'b0;
        end else if (CLK_EN) begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            prod_hi_ff   <= nxt_prod_hi;
            prod_lo_ff   <= nxt_prod_lo;
            shf_ff       <= nxt_shf;
            mcand_ff     <= nxt_mcand;
            rcnt_ff      <= nxt_rcnt;
            armed_ff     <= nxt_armed;
            aux_we_ff    <= nxt_aux_we;
            aux_sel_ff   <= nxt_aux_sel;
            aux_ff       <= nxt_aux;
            sum_we_ff    <= nxt_sum_we;
            sum_ff       <= nxt_sum;
            n_ff         <= nxt_n;
            z_ff         <= nxt_z;
            c_ff         <= nxt_c;
            v_ff         <= nxt_v;
        end
    end

    // Output drive
    assign SUM_WE             = sum_we_ff;
    assign SUM_OUT            = sum_ff;
    assign OVERFLOW_COUNTER   = cnt_ff;
    assign MULT_RESULT_HIGH   = prod_hi_ff;
    assign MULT_RESULT_LOW    = prod_lo_ff;
    assign RESULT_SHIFT_FIELD = shf_ff;
    assign MULTIPLICAND_REG   = mcand_ff;
    assign REPEAT_COUNT_REG   = rcnt_ff;
    assign AUX_WE             = aux_we_ff;
    assign AUX_SEL            = aux_sel_ff;
    assign AUX_POINTER        = aux_ff;
    assign FLAG_N             = n_ff;
    assign FLAG_Z             = z_ff;
    assign FLAG_C             = c_ff;
    assign FLAG_V             = v_ff;

endmodule

// ### rlm_dec_model.sv
// Decoder and operand path model feeding rlm_exec
`timescale 1ns/100ps
module rlm_dec_model (
    input  wire logic        clk,            // Core clock
    input  wire logic        rst,            // Reset, active high
    input  wire logic        req,            // Issue request from bench
    input  wire logic [15:0] rq_word,        // Opcode to issue
    input  wire logic [15:0] rq_op,          // Operand to deliver
    output logic             instr_valid,    // Issue strobe
    output logic      [15:0] instr_word,     // Opcode word
    output logic      [15:0] mem_operand_16  // Fetched operand
);
    logic [15:0] last_word_ff;
    logic [15:0] last_op_ff;
    // Remember last values so idle lines never repeat them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_word_ff <= 16'h0000;
            last_op_ff   <= 16'h0000;
        end else if (req) begin
            last_word_ff <= rq_word;
            last_op_ff   <= rq_op;
        end
    end
    // Operand valid only with the issue strobe, inverted junk otherwise
    assign instr_valid    = req;
    assign instr_word     = req ? rq_word : ~last_word_ff;
    assign mem_operand_16 = req ? rq_op : ~last_op_ff;
endmodule

// ### rlm_exec_checker.sv
// Concurrent checks on rlm_exec ports
`timescale 1ns/100ps
module rlm_exec_checker
    import rlm_pkg::*;
(
    input wire logic        MCLK,               // Core clock
    input wire logic        RESET,              // Asynchronous reset
    input wire logic        CLK_EN,             // Clock enable
    input wire logic        INSTR_VALID,        // Issue strobe
    input wire logic [15:0] INSTR_WORD,         // Opcode word
    input wire logic [15:0] MEM_OPERAND_16,     // Operand
    input wire logic        REPEAT_PREFIX,      // Repeat prefix strobe
    input wire logic [21:0] PC_IN,              // Program counter
    input wire logic [31:0] SUM_IN,             // Core sum
    input wire logic        READY,              // Idle
    input wire logic        SUM_WE,             // Sum write pulse
    input wire logic [31:0] SUM_OUT,            // New sum
    input wire logic [5:0]  OVERFLOW_COUNTER,   // Overflow counter
    input wire logic [15:0] MULT_RESULT_HIGH,   // Product upper half
    input wire logic [15:0] MULT_RESULT_LOW,    // Product lower half
    input wire logic [2:0]  RESULT_SHIFT_FIELD, // Shift field
    input wire logic [31:0] MULTIPLICAND_REG,   // Multiplicand
    input wire logic [15:0] REPEAT_COUNT_REG,   // Remaining repeats
    input wire logic        AUX_WE,             // Aux write pulse
    input wire logic [2:0]  AUX_SEL,            // Aux index
    input wire logic [31:0] AUX_POINTER,        // Aux data
    input wire logic        FLAG_N,             // Negative flag
    input wire logic        FLAG_Z,             // Zero flag
    input wire logic        FLAG_C,             // Carry flag
    input wire logic        FLAG_V              // Overflow flag
);
    logic taken;
    // Instruction accepted at this edge
    assign taken = CLK_EN && READY && INSTR_VALID && !REPEAT_PREFIX;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Register load effects one cycle after acceptance
    a_cnt_load: assert property (taken && INSTR_WORD == OP_LOAD_OVF_CNT |=> OVERFLOW_COUNTER ==
        $past(MEM_OPERAND_16[15:10]) && $stable(FLAG_N) && $stable(FLAG_V)) else $error("counter load wrong");
    a_prod_high: assert property (taken && INSTR_WORD[15:8] == OP_LOAD_PROD_HIGH |=>
        MULT_RESULT_HIGH == $past(MEM_OPERAND_16) && $stable(MULT_RESULT_LOW)) else $error("product high wrong");
    a_prod_low: assert property (taken && INSTR_WORD[15:8] == OP_LOAD_PROD_LOW |=>
        MULT_RESULT_LOW == $past(MEM_OPERAND_16) && $stable(MULT_RESULT_HIGH)) else $error("product low wrong");
    a_shift_load: assert property (taken && (INSTR_WORD & MASK_LOAD_SHIFT) == OP_LOAD_SHIFT |=>
        RESULT_SHIFT_FIELD == ($past(INSTR_WORD[0]) ? $past(SUM_IN[18:16]) : $past(SUM_IN[2:0])))
        else $error("shift field wrong");
    a_mcand_load: assert property (taken && INSTR_WORD[15:8] == OP_LOAD_MCAND |=>
        MULTIPLICAND_REG[31:16] == $past(MEM_OPERAND_16) && $stable(MULTIPLICAND_REG[15:0]))
        else $error("multiplicand load wrong");
    a_mcand_clear: assert property (taken && INSTR_WORD == OP_CLR_MCAND_LOW |=>
        MULTIPLICAND_REG[15:0] == ZERO_HALF && $stable(MULTIPLICAND_REG[31:16])) else $error("clear low wrong");
    a_pc_save: assert property (taken && (INSTR_WORD & MASK_SAVE_PC) == OP_SAVE_PC |=> AUX_WE &&
        AUX_SEL == $past(INSTR_WORD[2:0]) && AUX_POINTER == {10'h000, $past(PC_IN)}) else $error("pc save wrong");
    a_acc_start: assert property (taken && INSTR_WORD[15:8] == OP_LOAD_MCAND_ADD |=> SUM_WE &&
        MULTIPLICAND_REG[31:16] == $past(MEM_OPERAND_16)) else $error("accumulate start wrong");
    a_flag_nz: assert property (SUM_WE |-> FLAG_N == SUM_OUT[31] && FLAG_Z == (SUM_OUT == RST_WORD))
        else $error("negative or zero flag wrong");
    a_ovf_sticky: assert property (FLAG_V |=> FLAG_V) else $error("overflow flag cleared");
    a_repeat_clear: assert property (taken && INSTR_WORD[15:8] != OP_LOAD_MCAND_ADD && REPEAT_COUNT_REG != RST_REPEAT
        |=> REPEAT_COUNT_REG == RST_REPEAT && READY) else $error("repeat count not cleared");
    // Main scenarios reached
    c_cnt_load: cover property (taken && INSTR_WORD == OP_LOAD_OVF_CNT);
    c_mac_repeat: cover property (SUM_WE && !READY);
    c_pc_save: cover property (AUX_WE);
endmodule
bind rlm_exec rlm_exec_checker i_rlm_exec_checker (.*);

// ### rlm_exec_tb_top.sv
// Self-checking testbench of rlm_exec
`timescale 1ns/100ps
module rlm_exec_tb_top;
    import rlm_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, req = 1'b0, rep_load = 1'b0, sat_en = 1'b0, clk_en = 1'b1;
    logic [15:0] rq_word = 16'h0000, rq_op = 16'h0000, rep_n = 16'h0000;
    logic [21:0] pc = 22'h00_0000;
    logic [31:0] sum_in = 32'h0000_0000, sum_out, mcand, aux_ptr, last;
    logic        instr_valid, ready, sum_we, aux_we, f_n, f_z, f_c, f_v;
    logic [15:0] instr_word, mem_op, p_hi, p_lo, rep_reg;
    logic [5:0]  ovf_cnt;
    logic [2:0]  shf, aux_sel;
    int          err_total = 0, n_checks = 0, cnt;
    localparam logic [15:0] HI = {OP_LOAD_PROD_HIGH, 8'h00}, LO = {OP_LOAD_PROD_LOW, 8'h00};
    localparam logic [15:0] MAC = {OP_LOAD_MCAND_ADD, 8'h00};
    rlm_dec_model i_rlm_dec_model (.clk(mclk), .rst(reset), .req(req), .rq_word(rq_word), .rq_op(rq_op),
        .instr_valid(instr_valid), .instr_word(instr_word), .mem_operand_16(mem_op));
    rlm_exec i_rlm_exec (.MCLK(mclk), .RESET(reset), .CLK_EN(clk_en), .INSTR_VALID(instr_valid),
        .INSTR_WORD(instr_word), .MEM_OPERAND_16(mem_op), .REPEAT_PREFIX(rep_load), .REPEAT_N(rep_n),
        .PC_IN(pc), .SUM_IN(sum_in), .SATURATE_ENABLE(sat_en), .READY(ready), .SUM_WE(sum_we),
        .SUM_OUT(sum_out), .OVERFLOW_COUNTER(ovf_cnt), .MULT_RESULT_HIGH(p_hi), .MULT_RESULT_LOW(p_lo),
        .RESULT_SHIFT_FIELD(shf), .MULTIPLICAND_REG(mcand), .REPEAT_COUNT_REG(rep_reg), .AUX_WE(aux_we),
        .AUX_SEL(aux_sel), .AUX_POINTER(aux_ptr), .FLAG_N(f_n), .FLAG_Z(f_z), .FLAG_C(f_c), .FLAG_V(f_v));
    // Clock at 200 MHz
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask
    // One instruction through the decoder model
    task automatic issue(input logic [15:0] w, input logic [15:0] op, input logic [31:0] s);
        @(posedge mclk);
        req <= 1'b1;
        rq_word <= w;
        rq_op <= op;
        sum_in <= s;
        @(posedge mclk);
        req <= 1'b0;
        #1;
    endtask
    task automatic prefix(input logic [15:0] n);
        @(posedge mclk);
        rep_load <= 1'b1;
        rep_n <= n;
        @(posedge mclk);
        rep_load <= 1'b0;
        #1;
        chk(rep_reg === n, "repeat count load");
    endtask
    task automatic t_loads();
        issue(OP_LOAD_OVF_CNT, 16'hA7FF, 32'h0000_0000);
        chk(ovf_cnt === 6'h29 && f_n === 1'b0 && f_v === 1'b0, "counter load");
        issue(HI, 16'h1357, 32'h0000_0000);
        issue(LO, 16'h2468, 32'h0000_0000);
        chk({p_hi, p_lo} === 32'h1357_2468, "product halves");
        issue({OP_LOAD_MCAND, 8'h00}, 16'hBEEF, 32'h0000_0000);
        issue(OP_CLR_MCAND_LOW, 16'h0000, 32'h0000_0000);
        chk(mcand === 32'hBEEF_0000, "multiplicand halves");
        @(posedge mclk);
        pc <= 22'h2A_BCDE;
        issue(OP_SAVE_PC | 16'h0005, 16'h0000, 32'h0000_0000);
        chk(aux_we === 1'b1 && aux_sel === 3'h5 && aux_ptr === 32'h002A_BCDE, "pc save");
        // Clock enable low: an issued load must leave the product upper half and the aux write pulse frozen
        @(posedge mclk);
        clk_en <= 1'b0;
        issue(HI, 16'h0F0F, 32'h0000_0000);
        chk(p_hi === 16'h1357 && aux_we === 1'b0, "clock enable hold");
        @(posedge mclk);
        clk_en <= 1'b1;
        $display("test loads done");
    endtask
    task automatic t_accum();
        issue(HI, 16'h4000, 32'h0000_0000);
        issue(LO, 16'h0000, 32'h0000_0000);
        issue(OP_LOAD_SHIFT, 16'h0000, 32'h0000_0000);
        chk(shf === 3'h0, "shift field low half");
        issue(MAC, 16'h1234, 32'h8000_0000);
        chk(sum_we === 1'b1 && sum_out === 32'h0000_0000 && mcand[31:16] === 16'h1234, "left shift sum");
        chk(f_z === 1'b1 && f_n === 1'b0 && f_c === 1'b1 && f_v === 1'b1 && ovf_cnt === 6'h28, "flags");
        @(posedge mclk);
        sat_en <= 1'b1;
        issue(MAC, 16'h1234, 32'h8000_0000);
        chk(sum_out === SAT_NEG && ovf_cnt === 6'h28 && f_n === 1'b1, "saturate");
        @(posedge mclk);
        sat_en <= 1'b0;
        issue(HI, 16'hFFFF, 32'h0000_0000);
        issue(LO, 16'hFFF0, 32'h0000_0000);
        issue(OP_LOAD_SHIFT | 16'h0001, 16'h0000, 32'h0003_0000);
        chk(shf === 3'h3, "shift field high half");
        issue(MAC, 16'h0000, 32'h0000_0004);
        chk(sum_out === 32'h0000_0000 && f_c === 1'b1 && f_z === 1'b1 && f_v === 1'b1, "right shift");
        $display("test accumulate done");
    endtask
    task automatic t_repeat();
        issue(HI, 16'h0000, 32'h0000_0000);
        issue(LO, 16'h0100, 32'h0000_0000);
        issue(OP_LOAD_SHIFT, 16'h0000, 32'h0000_0001);
        prefix(16'h0002);
        issue(MAC, 16'h0000, 32'h0000_0010);
        cnt = 0;
        repeat (6) begin
            if (sum_we === 1'b1) begin
                cnt++;
                last = sum_out;
            end
            @(posedge mclk);
            #1;
        end
        chk(cnt == 3 && last === 32'h0000_0310 && f_z === 1'b0 && f_c === 1'b0 && f_v === 1'b1, "repeat");
        prefix(16'h0003);
        issue(HI, 16'h7777, 32'h0000_0000);
        chk(rep_reg === 16'h0000 && p_hi === 16'h7777 && ready === 1'b1, "non repeatable");
        $display("test repeat done");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        t_loads();
        t_accum();
        t_repeat();
        summarize();
    end
    // Watchdog
    initial begin
        #4000;
        err_total++;
        summarize();
    end
endmodule
